// >>> core/rpmp_pkg.sv
// package for the receive-port mode and paging register bank
// assumes one 100 MHz clock and a local i2c front end
package rpmp_pkg;

  localparam int NPORT = 2;
  localparam int MODE_W = 3;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] REG_RX_CTL = 8'h0C;
  localparam logic [7:0] REG_PAGE = 8'h4C;
  localparam logic [7:0] REG_ALIAS = 8'h5C;
  localparam logic [7:0] REG_PCFG = 8'h6D;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] RX_CTL_RST = 8'h00;
  localparam logic [7:0] ALIAS_RST = 8'h00;
  localparam logic [MODE_W-1:0] MODE_RST = 3'h0;
  // device address; value is arbitrary
  localparam logic [6:0] DEV_ADDR = 7'h30;

  // ****************************************
  // field positions
  // ****************************************
  localparam int ALIAS_EN_BIT = 0;
  localparam int ALIAS_ADDR_LSB = 1;
  localparam int PAGE_PORT_BIT = 0;

  // ****************************************
  // strap mode codes
  // ****************************************
  typedef enum logic [MODE_W-1:0] {
    MODE_ASYNC_PKT = 3'h0,
    MODE_WIDE_LOW = 3'h1,
    MODE_WIDE_HIGH = 3'h2,
    MODE_TEN_BIT = 3'h3,
    MODE_SYNC_PKT = 3'h4
  } rpmp_mode_t;

  // ****************************************
  // timing
  // ****************************************
  localparam longint CLK_HZ = 100_000_000;
  localparam longint REF_NOM_HZ = 25_000_000;
  localparam longint STRAP_DELAY_MS = 1;
  localparam longint REF_TIMEOUT_US = 20;
  localparam int STRAP_DELAY_TICKS =
    int'(REF_NOM_HZ / 1000 * STRAP_DELAY_MS);
  localparam logic [11:0] REF_TIMEOUT_CYC =
    12'(CLK_HZ / 1_000_000 * REF_TIMEOUT_US);
  localparam logic [1:0] OSC_DIV_LAST =
    2'(CLK_HZ / REF_NOM_HZ - 1);

  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_WAIT = 2'b01,
    ST_RUN = 2'b10
  } rpmp_state_t;

  typedef struct packed {
    logic valid;
    logic wr;
    logic remote;
    logic link_port;
    logic [6:0] dev_addr;
    logic [7:0] reg_addr;
    logic [7:0] wdata;
  } rpmp_acc_t;

  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
  } rpmp_rsp_t;

endpackage

// >>> core/rpmp_top.sv
// receive-port mode strap, port disable and paging register bank
// assumes acc comes from the i2c target front end, one cycle per access,
// and that all inputs are synchronous to clk
// Summary of operation
// RULE1: wait 1 ms after release, then sample
// RULE2: decode strap into one of five codes
// RULE3: strap mode lands in software-writable field
// RULE4: input mode held per receive port
// RULE5: timers counted from reference clock ticks
// RULE6: outside source keeps reference clock running
// RULE7: internal oscillator tick until reference seen
// RULE8: port 0, port 1 or both accepted
// RULE9: control register bits disable receive ports
// RULE10: remote writes to disable bits dropped
// RULE11: page select steers port-private accesses
// RULE12: page select defaults to accessing port
// RULE13: per-port alias address reaches private registers
// RULE14: alias address also reaches shared registers
// RULE15: strap sampled once per release; software wins afterwards
`timescale 1ns/1ns
module rpmp_top
  import rpmp_pkg::*;
#(
  parameter int DELAY_TICKS = STRAP_DELAY_TICKS
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic powerdown_release_pin,
  input wire logic external_timing_source,
  input wire logic [MODE_W-1:0] strap_code,
  input wire rpmp_acc_t acc,
  output rpmp_rsp_t rsp,
  output logic [NPORT-1:0][MODE_W-1:0] port_mode,
  output logic [NPORT-1:0] rx_enable,
  output logic [MODE_W-1:0] cfg_code,
  output logic strap_done,
  output logic ref_in_use
);

  // ****************************************
  // timebase
  // ****************************************
  logic ref_prev_r, ref_prev_nxt;
  logic ref_valid_r, ref_valid_nxt;
  logic [11:0] ref_idle_r, ref_idle_nxt;
  logic [1:0] osc_cnt_r, osc_cnt_nxt;
  logic tick;

  always_comb
  begin
    logic ref_edge;
    logic osc_tick;
    ref_edge = external_timing_source & ~ref_prev_r;
    osc_tick = (osc_cnt_r == OSC_DIV_LAST);
    ref_prev_nxt = external_timing_source;
    ref_idle_nxt = ref_idle_r;
    ref_valid_nxt = ref_valid_r;
    osc_cnt_nxt = osc_tick ? 2'h0 : osc_cnt_r + 2'h1;
    if (ref_edge)
    begin
      ref_idle_nxt = 12'h000;
      ref_valid_nxt = 1'b1;
    end
    else if (ref_idle_r == REF_TIMEOUT_CYC)
    begin
      // a stalled reference drops back to the oscillator
      ref_valid_nxt = 1'b0;
    end
    else
    begin
      ref_idle_nxt = ref_idle_r + 12'h001;
    end
    // RULE7: backup oscillator tick
    // RULE5: one tick source for timers
    tick = ref_valid_r ? ref_edge : osc_tick;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ref_prev_r <= 1'b0;
      ref_valid_r <= 1'b0;
      ref_idle_r <= 12'h000;
      osc_cnt_r <= 2'h0;
    end
    else
    begin
      ref_prev_r <= ref_prev_nxt;
      ref_valid_r <= ref_valid_nxt;
      ref_idle_r <= ref_idle_nxt;
      osc_cnt_r <= osc_cnt_nxt;
    end
  end

  // ****************************************
  // strap sequencer
  // ****************************************
  rpmp_state_t state_r, state_nxt;
  logic [15:0] dly_r, dly_nxt;
  logic [MODE_W-1:0] code_r, code_nxt;
  logic sample;

  always_comb
  begin
    state_nxt = state_r;
    dly_nxt = dly_r;
    code_nxt = code_r;
    sample = 1'b0;
    case (state_r)
      ST_OFF:
      begin
        dly_nxt = 16'h0000;
        if (powerdown_release_pin)
        begin
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        // RULE1: settle delay before sampling
        if (tick)
        begin
          if (dly_r == 16'(DELAY_TICKS - 1))
          begin
            sample = 1'b1;
            state_nxt = ST_RUN;
          end
          else
          begin
            dly_nxt = dly_r + 16'h0001;
          end
        end
      end
      default:
      begin
      end
    endcase
    if (sample)
    begin
      // RULE2: reserved codes fold to mode 0
      if (strap_code > MODE_SYNC_PKT)
      begin
        code_nxt = MODE_ASYNC_PKT;
      end
      else
      begin
        code_nxt = strap_code;
      end
    end
    if (!powerdown_release_pin)
    begin
      // RULE15: next release samples again
      state_nxt = ST_OFF;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r <= ST_OFF;
      dly_r <= 16'h0000;
      code_r <= MODE_RST;
    end
    else
    begin
      state_r <= state_nxt;
      dly_r <= dly_nxt;
      code_r <= code_nxt;
    end
  end

  // ****************************************
  // register bank
  // ****************************************
  logic [7:0] rx_ctl_r, rx_ctl_nxt;
  logic lpage_r, lpage_nxt;
  logic [NPORT-1:0] rpage_r, rpage_nxt;
  logic [NPORT-1:0][7:0] alias_r, alias_nxt;
  logic [NPORT-1:0][MODE_W-1:0] mode_r, mode_nxt;
  rpmp_rsp_t rsp_r, rsp_nxt;
  logic [NPORT-1:0] rx_en_r, rx_en_nxt;

  always_comb
  begin
    logic hit;
    logic tgt;
    logic page;
    rx_ctl_nxt = rx_ctl_r;
    lpage_nxt = lpage_r;
    rpage_nxt = rpage_r;
    alias_nxt = alias_r;
    mode_nxt = mode_r;
    rsp_nxt = '0;
    page = acc.remote ? rpage_r[acc.link_port] : lpage_r;
    hit = (acc.dev_addr == DEV_ADDR);
    // RULE11: page picks the private set
    tgt = page;
    for (int i = 0; i < NPORT; i++)
    begin
      // RULE13: alias bypasses the page
      if (alias_r[i][ALIAS_EN_BIT] &&
          acc.dev_addr == alias_r[i][7:ALIAS_ADDR_LSB])
      begin
        hit = 1'b1;
        tgt = 1'(i);
      end
    end
    // RULE14: shared registers on any hit
    if (acc.valid && hit)
    begin
      rsp_nxt.ack = 1'b1;
      if (acc.reg_addr == REG_RX_CTL)
      begin
        rsp_nxt.rdata = rx_ctl_r;
        // RULE10: local writes only
        if (acc.wr && !acc.remote)
        begin
          rx_ctl_nxt = acc.wdata;
        end
      end
      else if (acc.reg_addr == REG_PAGE)
      begin
        rsp_nxt.rdata = {7'h00, page};
        if (acc.wr && acc.remote)
        begin
          rpage_nxt[acc.link_port] = acc.wdata[PAGE_PORT_BIT];
        end
        else if (acc.wr)
        begin
          lpage_nxt = acc.wdata[PAGE_PORT_BIT];
        end
      end
      else if (acc.reg_addr == REG_ALIAS)
      begin
        rsp_nxt.rdata = alias_r[tgt];
        if (acc.wr)
        begin
          alias_nxt[tgt] = acc.wdata;
        end
      end
      else if (acc.reg_addr == REG_PCFG)
      begin
        rsp_nxt.rdata = {5'h00, mode_r[tgt]};
        // RULE3: software override of mode
        // RULE4: one mode per port
        if (acc.wr)
        begin
          mode_nxt[tgt] = acc.wdata[MODE_W-1:0];
        end
      end
      else
      begin
        // unmapped offsets read zero, writes dropped
        rsp_nxt.rdata = 8'h00;
      end
    end
    if (sample)
    begin
      // RULE3: strap loads every port field
      for (int i = 0; i < NPORT; i++)
      begin
        mode_nxt[i] = code_nxt;
      end
    end
    // RULE8: each port enabled on its own
    // RULE9: disable bit stops the port
    for (int i = 0; i < NPORT; i++)
    begin
      rx_en_nxt[i] = (state_r == ST_RUN) & ~rx_ctl_r[i];
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_ctl_r <= RX_CTL_RST;
      // RULE12: local default port 0
      lpage_r <= 1'b0;
      rsp_r <= '0;
      rx_en_r <= '0;
      for (int i = 0; i < NPORT; i++)
      begin
        // RULE12: remote default own port
        rpage_r[i] <= 1'(i);
        alias_r[i] <= ALIAS_RST;
        mode_r[i] <= MODE_RST;
      end
    end
    else
    begin
      rx_ctl_r <= rx_ctl_nxt;
      lpage_r <= lpage_nxt;
      rpage_r <= rpage_nxt;
      alias_r <= alias_nxt;
      mode_r <= mode_nxt;
      rsp_r <= rsp_nxt;
      rx_en_r <= rx_en_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  logic done_r;
  logic use_r;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      done_r <= 1'b0;
      use_r <= 1'b0;
    end
    else
    begin
      done_r <= (state_nxt == ST_RUN);
      use_r <= ref_valid_nxt;
    end
  end

  assign rsp = rsp_r;
  assign port_mode = mode_r;
  assign rx_enable = rx_en_r;
  assign cfg_code = code_r;
  assign strap_done = done_r;
  assign ref_in_use = use_r;

endmodule

// >>> verification/rpmp_ref_model.sv
// reference clock source on the far side of the bank
// assumes en comes from the bench; a stopped source holds low
`timescale 1ns/1ns
module rpmp_ref_model
(
  input wire logic en,
  output logic ref_wave
);
  initial
  begin
    ref_wave = 1'b0;
    #3;
    forever
    begin
      #20;
      ref_wave = en ? ~ref_wave : 1'b0;
    end
  end
endmodule

// >>> verification/rpmp_sva.sv
// assertion checker for the mode strap and paging bank
// assumes it is bound into rpmp_top and sees only its ports
`timescale 1ns/1ns
module rpmp_sva
  import rpmp_pkg::*;
#(
  parameter int DELAY_TICKS = STRAP_DELAY_TICKS
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic powerdown_release_pin,
  input wire logic external_timing_source,
  input wire rpmp_acc_t acc,
  input wire rpmp_rsp_t rsp,
  input wire logic [NPORT-1:0][MODE_W-1:0] port_mode,
  input wire logic [NPORT-1:0] rx_enable,
  input wire logic [MODE_W-1:0] cfg_code,
  input wire logic strap_done,
  input wire logic ref_in_use
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // wide enough for the full-length strap delay at the default parameter
  logic [31:0] hi_r, hi_nxt;
  logic [15:0] gap_r, gap_nxt;
  logic ref_q_r;
  logic rx_wr;
  assign rx_wr = acc.valid && acc.wr && acc.dev_addr == DEV_ADDR &&
    acc.reg_addr == REG_RX_CTL;
  // cycles since release and since the last reference edge
  always_comb
  begin
    hi_nxt = powerdown_release_pin ? hi_r + 32'h0000_0001 : 32'h0000_0000;
    gap_nxt = (external_timing_source && !ref_q_r) ? 16'h0000 :
      gap_r + 16'h0001;
  end
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hi_r <= 32'h0000_0000;
      gap_r <= 16'h0000;
      ref_q_r <= 1'b0;
    end
    else
    begin
      hi_r <= hi_nxt;
      gap_r <= gap_nxt;
      ref_q_r <= external_timing_source;
    end
  end
  property p_ack;
    acc.valid && acc.dev_addr == DEV_ADDR |=> rsp.ack;
  endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_quiet;
    !acc.valid |=> !rsp.ack && rsp.rdata == 8'h00;
  endproperty
  a_quiet: assert property (p_quiet) else $error("stray ack");
  property p_off;
    !powerdown_release_pin[*3] |-> rx_enable == 2'b00 && !strap_done;
  endproperty
  a_off: assert property (p_off) else $error("active in off");
  property p_load;
    $rose(strap_done) && !$past(acc.valid) |-> cfg_code <= 3'h4 &&
      port_mode[0] == cfg_code && port_mode[1] == cfg_code;
  endproperty
  a_load: assert property (p_load) else $error("bad load");
  property p_delay;
    $rose(strap_done) |-> hi_r >= 32'(4 * DELAY_TICKS - 8);
  endproperty
  a_delay: assert property (p_delay) else $error("early");
  property p_lost;
    gap_r > 16'h07da |-> !ref_in_use;
  endproperty
  a_lost: assert property (p_lost) else $error("stale ref");
  property p_seen;
    external_timing_source && !ref_q_r |-> ##[1:8] ref_in_use;
  endproperty
  a_seen: assert property (p_seen) else $error("ref unused");
  property p_remote;
    // a local write just before, or a fresh start, may still move the enables
    rx_wr && acc.remote && strap_done && $past(strap_done) &&
      !$past(rx_wr && !acc.remote) |=>
      ($stable(rx_enable) || !strap_done)[*2];
  endproperty
  a_remote: assert property (p_remote) else $error("remote");
  property p_local;
    rx_wr && !acc.remote && strap_done |=> ##1
      (rx_enable & $past(acc.wdata[1:0], 2)) == 2'b00;
  endproperty
  a_local: assert property (p_local) else $error("not off");
endmodule

bind rpmp_top rpmp_sva #(.DELAY_TICKS(DELAY_TICKS)) u_sva (
  .clk(clk),
  .arst_n(arst_n),
  .powerdown_release_pin(powerdown_release_pin),
  .external_timing_source(external_timing_source),
  .acc(acc),
  .rsp(rsp),
  .port_mode(port_mode),
  .rx_enable(rx_enable),
  .cfg_code(cfg_code),
  .strap_done(strap_done),
  .ref_in_use(ref_in_use)
);

// >>> verification/test_rx_port_mode_and_paging.sv
// self-checking bench for the mode strap and paging bank
// assumes rpmp_top, its bound checker and the reference model
`timescale 1ns/1ns
module test_rx_port_mode_and_paging;
  import rpmp_pkg::*;
  logic clk, arst_n, pin, ref_en, ref_w, ack, sd, riu;
  logic [MODE_W-1:0] strap, cfg;
  rpmp_acc_t acc;
  rpmp_rsp_t rsp;
  logic [NPORT-1:0][MODE_W-1:0] pm;
  logic [NPORT-1:0] rxe;
  logic [7:0] rd;
  int error_cnt, num_checks, cyc;
  // strap code beside the mode it should load
  logic [5:0] rows [8] = '{6'h00, 6'h09, 6'h12, 6'h1b, 6'h24, 6'h28,
    6'h30, 6'h38};
  rpmp_top #(.DELAY_TICKS(5)) dut (.clk(clk), .arst_n(arst_n),
    .powerdown_release_pin(pin), .external_timing_source(ref_w),
    .strap_code(strap), .acc(acc), .rsp(rsp), .port_mode(pm),
    .rx_enable(rxe), .cfg_code(cfg), .strap_done(sd), .ref_in_use(riu));
  rpmp_ref_model u_ref (.en(ref_en), .ref_wave(ref_w));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [7:0] e,
    input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(input logic [6:0] d, input logic [7:0] a,
    input logic w, input logic [7:0] wd, input logic rm, input logic lp);
    @(posedge clk);
    acc <= '{1'b1, w, rm, lp, d, a, wd};
    @(posedge clk);
    acc.valid <= 1'b0;
    #1;
    ack = rsp.ack;
    rd = rsp.rdata;
  endtask
  task automatic strap_run(input logic [2:0] s);
    @(posedge clk);
    pin <= 1'b0;
    strap <= s;
    repeat (3) @(posedge clk);
    pin <= 1'b1;
    for (int k = 0; k < 200 && sd !== 1'b1; k++)
      @(posedge clk);
    #1;
    chk("strap_done", 8'h01, {7'h00, sd});
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      error_cnt++;
      wrap_up();
    end
  end
  initial
  begin
    arst_n = 1'b0;
    pin = 1'b0;
    ref_en = 1'b1;
    strap = 3'h0;
    acc = '0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    #1;
    chk("reset", 8'h00, {pm, rxe});
    foreach (rows[i])
    begin
      strap_run(rows[i][5:3]);
      chk("modes", {2'b00, rows[i][2:0], rows[i][2:0]}, {2'b00, pm});
      chk("cfg", {5'h00, rows[i][2:0]}, {5'h00, cfg});
      bus(DEV_ADDR, REG_PCFG, 1'b0, 8'h00, 1'b0, 1'b0);
      chk("pcfg", {5'h00, rows[i][2:0]}, rd);
    end
    chk("rx_both", 8'h03, {6'h00, rxe});
    bus(DEV_ADDR, REG_PCFG, 1'b1, 8'h03, 1'b0, 1'b0);
    bus(DEV_ADDR, REG_PAGE, 1'b1, 8'h01, 1'b0, 1'b0);
    bus(DEV_ADDR, REG_PCFG, 1'b1, 8'h04, 1'b0, 1'b0);
    bus(DEV_ADDR, REG_PCFG, 1'b0, 8'h00, 1'b0, 1'b0);
    chk("paged", 8'h04, rd);
    chk("ports", 8'h23, {2'b00, pm});
    // a strap change while released must not be sampled again
    @(posedge clk);
    strap <= 3'h1;
    repeat (40) @(posedge clk);
    #1;
    chk("no_resample", 8'h23, {2'b00, pm});
    bus(DEV_ADDR, REG_PAGE, 1'b0, 8'h00, 1'b1, 1'b1);
    chk("page_dflt", 8'h01, rd);
    bus(DEV_ADDR, REG_PAGE, 1'b1, 8'h01, 1'b1, 1'b0);
    bus(DEV_ADDR, REG_PCFG, 1'b0, 8'h00, 1'b1, 1'b0);
    chk("remote_page", 8'h04, rd);
    bus(DEV_ADDR, REG_RX_CTL, 1'b1, 8'h03, 1'b1, 1'b0);
    bus(DEV_ADDR, REG_RX_CTL, 1'b0, 8'h00, 1'b0, 1'b0);
    chk("remote_wr", 8'h00, rd);
    bus(DEV_ADDR, REG_RX_CTL, 1'b1, 8'h01, 1'b0, 1'b0);
    bus(DEV_ADDR, REG_RX_CTL, 1'b0, 8'h00, 1'b0, 1'b0);
    chk("rx_off", 8'h02, {6'h00, rxe});
    bus(DEV_ADDR, REG_ALIAS, 1'b1, 8'h83, 1'b0, 1'b0);
    // page back to port 0 so only the alias can reach port 1
    bus(DEV_ADDR, REG_PAGE, 1'b1, 8'h00, 1'b0, 1'b0);
    bus(7'h41, REG_PCFG, 1'b0, 8'h00, 1'b0, 1'b0);
    chk("alias", 8'h04, rd);
    bus(7'h41, REG_RX_CTL, 1'b0, 8'h00, 1'b0, 1'b0);
    chk("alias_shr", 8'h01, rd);
    bus(DEV_ADDR, 8'h01, 1'b0, 8'h00, 1'b0, 1'b0);
    chk("unmap_ack", 8'h01, {7'h00, ack});
    chk("unmap_rd", 8'h00, rd);
    bus(7'h42, REG_PCFG, 1'b0, 8'h00, 1'b0, 1'b0);
    chk("no_ack", 8'h00, {7'h00, ack});
    chk("ref_on", 8'h01, {7'h00, riu});
    // stopped source must fall back to the oscillator
    ref_en <= 1'b0;
    repeat (2100) @(posedge clk);
    #1;
    chk("ref_lost", 8'h00, {7'h00, riu});
    strap_run(3'h2);
    chk("osc_modes", 8'h12, {2'b00, pm});
    ref_en <= 1'b1;
    repeat (20) @(posedge clk);
    #1;
    chk("ref_back", 8'h01, {7'h00, riu});
    wrap_up();
  end
endmodule
